// File: hw/eds_defines.svh
// eds_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by the sram, timing and top design files of the data-memory access unit
`ifndef EDS_DEFINES_SVH
`define EDS_DEFINES_SVH

// register byte addresses on the ahb-lite bus
`define EDS_OFS_CTRL 8'h00
`define EDS_OFS_ADDR 8'h04
`define EDS_OFS_WDATA 8'h08
`define EDS_OFS_CMD 8'h0C
`define EDS_OFS_STATUS 8'h10
`define EDS_OFS_RDATA 8'h14

// control register fields
`define EDS_CTRL_STRETCH_LSB 0
`define EDS_CTRL_STRETCH_MSB 2
`define EDS_CTRL_SEL_LO_BIT 4
`define EDS_CTRL_SEL_HI_BIT 5
`define EDS_STRETCH_RESET 3'h1
`define EDS_SEL_RESET 2'h0

// command and status fields
`define EDS_CMD_START_BIT 0
`define EDS_CMD_WRITE_BIT 1
`define EDS_ST_BUSY_BIT 0
`define EDS_ST_DONE_BIT 1
`define EDS_ST_BLOCKED_BIT 2
`define EDS_ST_INTERNAL_BIT 3
`define EDS_ST_LOCK_LSB 8
`define EDS_ST_LOCK_MSB 10

// address map
`define EDS_SRAM_LAST 16'h03FF
`define EDS_BLOCK_LAST 16'hFFFB
`define EDS_LOCK_ADDR 16'hFFFC
`define EDS_SRAM_AW 10
`define EDS_SRAM_WORDS 1024

// timing: one hclk is one crystal clock, four of them make a machine cycle
`define EDS_CLK_PERIOD_NS 100
`define EDS_PH_PER_MC 6'd4
`define EDS_INT_MC 6'd2
`define EDS_INT_CYCLES (`EDS_INT_MC * `EDS_PH_PER_MC)
`define EDS_ALE_BASE 6'd2
`define EDS_STROBE_S0 6'd2
`define EDS_EDGE_STEP 6'd1
`define EDS_SHORT_MC_BASE 6'd2
`define EDS_LONG_MC_BASE 6'd5
`define EDS_LONG_STRETCH 3'h4

`endif

// File: hw/eds_pkg.sv
// eds_pkg: types shared by the data-memory access unit
// assumes: eds_defines.svh supplies the numbers
package eds_pkg;
   typedef enum {EDS_IDLE, EDS_INT, EDS_EXT} eds_state_e;
   typedef enum {EDS_TGT_INT, EDS_TGT_EXT, EDS_TGT_LOCK, EDS_TGT_NONE} eds_target_e;
   // phase counts of one external access frame, in hclk cycles
   typedef struct packed {
      logic [5:0] ale;
      logic [5:0] setup;
      logic [5:0] strobe;
      logic [5:0] hold;
      logic [5:0] total;
   } eds_frame_s;
endpackage

// File: hw/eds_sram.sv
// eds_sram: 1 kbyte on-chip data sram held in flip-flops
// assumes: one write port, combinational read, single clock
`timescale 1ns/1ps
`include "eds_defines.svh"
module eds_sram (
   input wire logic clk,
   input wire logic we,
   input wire logic [`EDS_SRAM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [`EDS_SRAM_WORDS];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];
endmodule // eds_sram

// File: hw/eds_timing.sv
// eds_timing: turns a stretch value into the phase plan of an external access
// assumes: purely combinational, value latched by the caller at access start
`timescale 1ns/1ps
`include "eds_defines.svh"
module eds_timing
   import eds_pkg::*;
(
   input wire logic [2:0] stretch,
   output eds_frame_s frame
);
   logic long_frame;
   logic [5:0] s6;

   assign long_frame = (stretch >= `EDS_LONG_STRETCH);
   assign s6 = {3'h0, stretch};

   always_comb begin
      // address latch strobe widened by a machine cycle at 4 and up
      frame.ale = long_frame ? (`EDS_ALE_BASE + `EDS_PH_PER_MC) : `EDS_ALE_BASE;
      // one crystal clock of set-up from stretch 1 on
      frame.setup = (stretch == 3'h0) ? 6'h00 : `EDS_EDGE_STEP;
      // strobe width: half a machine cycle at 0, else stretch machine cycles
      frame.strobe = (stretch == 3'h0) ? `EDS_STROBE_S0 : 6'((s6 * `EDS_PH_PER_MC));
      // hold: one crystal clock from 1 on, one more machine cycle from 4 on
      frame.hold = ((stretch == 3'h0) ? 6'h00 : `EDS_EDGE_STEP)
         + (long_frame ? `EDS_PH_PER_MC : 6'h00);
      // instruction length: 2..5 then 9..12 machine cycles
      frame.total = 6'(((long_frame ? `EDS_LONG_MC_BASE : `EDS_SHORT_MC_BASE) + s6)
         * `EDS_PH_PER_MC);
   end
endmodule // eds_timing

// File: hw/eds_top.sv
// eds_top: data-memory access unit with internal sram, lock status and
// stretched multiplexed external bus, registers on ahb-lite
// assumes: zero-wait ahb-lite master, external pins synchronous to hclk
`timescale 1ns/1ps
`include "eds_defines.svh"
module eds_top
   import eds_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [2:0] security_lock_status,
   input wire logic [7:0] low_addr_data_port_in,
   output logic [7:0] low_addr_data_port_out,
   output logic low_addr_data_port_oe,
   output logic [7:0] high_addr_port_out,
   output logic ale_out,
   output logic rd_strobe_n,
   output logic wr_strobe_n,
   output logic ext_bus_active
);
   eds_state_e state_reg;
   eds_frame_s frame_now;
   eds_frame_s frame_reg;
   eds_target_e tgt;
   logic [2:0] stretch_reg;
   logic data_mem_sel_hi;
   logic data_mem_sel_lo;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata_reg;
   logic [2:0] lock_reg;
   logic dir_write_reg;
   logic done_reg;
   logic blocked_reg;
   logic internal_reg;
   logic [5:0] ph_reg;
   logic wr_pend_reg;
   logic [7:0] addr_pend_reg;
   logic cmd_start;
   logic addr_phase;
   logic sram_we;
   logic [7:0] sram_rdata;
   logic [5:0] b_addr;
   logic [5:0] b_strobe;
   logic [5:0] b_end;
   logic [5:0] b_hold;
   logic [31:0] rd_mux;

   // ---------------- ahb-lite slave ----------------
   assign addr_phase = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_pend_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         addr_pend_reg <= addr_phase ? haddr[7:0] : addr_pend_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         `EDS_OFS_CTRL: begin
            rd_mux[`EDS_CTRL_STRETCH_MSB:`EDS_CTRL_STRETCH_LSB] = stretch_reg;
            rd_mux[`EDS_CTRL_SEL_LO_BIT] = data_mem_sel_lo;
            rd_mux[`EDS_CTRL_SEL_HI_BIT] = data_mem_sel_hi;
         end
         `EDS_OFS_ADDR: rd_mux[15:0] = addr_reg;
         `EDS_OFS_WDATA: rd_mux[7:0] = wdata_reg;
         `EDS_OFS_STATUS: begin
            rd_mux[`EDS_ST_BUSY_BIT] = (state_reg != EDS_IDLE);
            rd_mux[`EDS_ST_DONE_BIT] = done_reg;
            rd_mux[`EDS_ST_BLOCKED_BIT] = blocked_reg;
            rd_mux[`EDS_ST_INTERNAL_BIT] = internal_reg;
            rd_mux[`EDS_ST_LOCK_MSB:`EDS_ST_LOCK_LSB] = lock_reg;
         end
         `EDS_OFS_RDATA: rd_mux[7:0] = rdata_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // control: stretch and memory select, writable at any time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stretch_reg <= `EDS_STRETCH_RESET;
         {data_mem_sel_hi, data_mem_sel_lo} <= `EDS_SEL_RESET;
      end else if (wr_pend_reg && addr_pend_reg == `EDS_OFS_CTRL) begin
         stretch_reg <= hwdata[`EDS_CTRL_STRETCH_MSB:`EDS_CTRL_STRETCH_LSB];
         data_mem_sel_lo <= hwdata[`EDS_CTRL_SEL_LO_BIT];
         data_mem_sel_hi <= hwdata[`EDS_CTRL_SEL_HI_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
      end else if (wr_pend_reg && state_reg == EDS_IDLE) begin
         if (addr_pend_reg == `EDS_OFS_ADDR) begin
            addr_reg <= hwdata[15:0];
         end
         if (addr_pend_reg == `EDS_OFS_WDATA) begin
            wdata_reg <= hwdata[7:0];
         end
      end
   end

   // lock status sampled every clock, read-only to software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_reg <= 3'h0;
      end else begin
         lock_reg <= security_lock_status;
      end
   end

   // ---------------- address decode ----------------
   assign cmd_start = wr_pend_reg && addr_pend_reg == `EDS_OFS_CMD
      && hwdata[`EDS_CMD_START_BIT] && state_reg == EDS_IDLE;

   always_comb begin
      tgt = EDS_TGT_EXT;
      unique case ({data_mem_sel_hi, data_mem_sel_lo})
         2'b01: begin
            // low 1k internal, the rest external
            tgt = (addr_reg <= `EDS_SRAM_LAST) ? EDS_TGT_INT : EDS_TGT_EXT;
         end
         2'b11: begin
            // no external access at all in this mode
            if (addr_reg <= `EDS_SRAM_LAST) begin
               tgt = EDS_TGT_INT;
            end else if (addr_reg == `EDS_LOCK_ADDR && !hwdata[`EDS_CMD_WRITE_BIT]) begin
               tgt = EDS_TGT_LOCK;
            end else begin
               tgt = EDS_TGT_NONE;
            end
         end
         default: tgt = EDS_TGT_EXT; // 00 default, 10 reserved
      endcase
   end

   eds_timing u_timing (
      .stretch(stretch_reg),
      .frame(frame_now)
   );

   // ---------------- access sequencer ----------------
   // frame and target fixed at the start of each access
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= EDS_IDLE;
         ph_reg <= 6'h00;
         frame_reg <= '0;
         dir_write_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            EDS_IDLE: begin
               ph_reg <= 6'h00;
               if (cmd_start) begin
                  dir_write_reg <= hwdata[`EDS_CMD_WRITE_BIT];
                  frame_reg <= frame_now;
                  state_reg <= (tgt == EDS_TGT_EXT) ? EDS_EXT : EDS_INT;
               end
            end
            EDS_INT: begin
               // fixed two machine cycles regardless of stretch
               ph_reg <= ph_reg + 6'h01;
               if (ph_reg == `EDS_INT_CYCLES - 6'h01) begin
                  state_reg <= EDS_IDLE;
               end
            end
            EDS_EXT: begin
               ph_reg <= ph_reg + 6'h01;
               if (ph_reg == frame_reg.total - 6'h01) begin
                  state_reg <= EDS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blocked_reg <= 1'b0;
         internal_reg <= 1'b0;
      end else if (cmd_start) begin
         blocked_reg <= (tgt == EDS_TGT_NONE);
         internal_reg <= (tgt != EDS_TGT_EXT);
      end
   end

   // done is sticky; a new completion wins over a software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= 1'b0;
      end else if (state_reg != EDS_IDLE && ph_reg == (state_reg == EDS_EXT
            ? frame_reg.total - 6'h01 : `EDS_INT_CYCLES - 6'h01)) begin
         done_reg <= 1'b1;
      end else if (cmd_start || (wr_pend_reg && addr_pend_reg == `EDS_OFS_STATUS
            && hwdata[`EDS_ST_DONE_BIT])) begin
         done_reg <= 1'b0;
      end
   end

   assign sram_we = cmd_start && tgt == EDS_TGT_INT && hwdata[`EDS_CMD_WRITE_BIT];

   eds_sram u_sram (
      .clk(hclk),
      .we(sram_we),
      .addr(addr_reg[`EDS_SRAM_AW-1:0]),
      .wdata(wdata_reg),
      .rdata(sram_rdata)
   );

   // ---------------- external bus pins ----------------
   assign b_addr = frame_reg.ale;
   assign b_strobe = frame_reg.ale + frame_reg.setup;
   assign b_end = b_strobe + frame_reg.strobe;
   assign b_hold = b_end + frame_reg.hold;

   // read data: sram/lock at start, external port at strobe end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 8'h00;
      end else if (cmd_start && !hwdata[`EDS_CMD_WRITE_BIT]) begin
         unique case (tgt)
            EDS_TGT_INT: rdata_reg <= sram_rdata;
            EDS_TGT_LOCK: rdata_reg <= {5'h00, lock_reg};
            EDS_TGT_NONE: rdata_reg <= 8'h00;
            EDS_TGT_EXT: rdata_reg <= rdata_reg;
         endcase
      end else if (state_reg == EDS_EXT && !dir_write_reg && ph_reg == b_end) begin
         rdata_reg <= low_addr_data_port_in;
      end
   end

   // stretch only shapes this data-move frame; no program fetch path here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_bus_active <= 1'b0;
         ale_out <= 1'b0;
         rd_strobe_n <= 1'b1;
         wr_strobe_n <= 1'b1;
         high_addr_port_out <= 8'h00;
         low_addr_data_port_out <= 8'h00;
         low_addr_data_port_oe <= 1'b0;
      end else begin
         // bus-active flag set for the whole access; each pin driven only in its own phase
         ext_bus_active <= (state_reg == EDS_EXT);
         ale_out <= (state_reg == EDS_EXT) && ph_reg < b_addr;
         rd_strobe_n <= !((state_reg == EDS_EXT) && !dir_write_reg
            && ph_reg >= b_strobe && ph_reg < b_end);
         wr_strobe_n <= !((state_reg == EDS_EXT) && dir_write_reg
            && ph_reg >= b_strobe && ph_reg < b_end);
         // high address held through the hold phase
         high_addr_port_out <= ((state_reg == EDS_EXT) && ph_reg < b_hold) ? addr_reg[15:8] : 8'h00;
         if (state_reg == EDS_EXT && ph_reg < b_addr) begin
            low_addr_data_port_out <= addr_reg[7:0];
            low_addr_data_port_oe <= 1'b1;
         end else if (state_reg == EDS_EXT && dir_write_reg && ph_reg < b_hold) begin
            low_addr_data_port_out <= wdata_reg;
            low_addr_data_port_oe <= 1'b1;
         end else begin
            low_addr_data_port_out <= 8'h00;
            low_addr_data_port_oe <= 1'b0;
         end
      end
   end

   // ---------------- assertions ----------------
   logic [5:0] str_cnt_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         str_cnt_reg <= 6'h00;
      end else begin
         str_cnt_reg <= (!rd_strobe_n || !wr_strobe_n) ? str_cnt_reg + 6'h01 : 6'h00;
      end
   end

   sequence int_run_s;
      (state_reg == EDS_INT)[*8] ##1 (state_reg == EDS_IDLE);
   endsequence

   sequence ext_s1_run_s;
      (state_reg == EDS_EXT)[*6] ##1 (state_reg == EDS_EXT)[*6] ##1 (state_reg == EDS_IDLE);
   endsequence

   int_two_mc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_start && tgt != EDS_TGT_EXT) |=> int_run_s)
      else $error("internal access not two machine cycles");

   ext_three_mc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_start && tgt == EDS_TGT_EXT && stretch_reg == 3'h1) |=> ext_s1_run_s)
      else $error("stretch 1 external access not three machine cycles");

   sel_off_ext_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_start && !data_mem_sel_lo) |=> (state_reg == EDS_EXT) ##1 ext_bus_active)
      else $error("disabled sram did not route to external bus");

   sel_on_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_start && {data_mem_sel_hi, data_mem_sel_lo} == 2'b01 && addr_reg > `EDS_SRAM_LAST)
      |=> state_reg == EDS_EXT)
      else $error("address above 1k not external");

   sel_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_start && {data_mem_sel_hi, data_mem_sel_lo} == 2'b11 && addr_reg > `EDS_SRAM_LAST)
      |=> blocked_reg == (addr_reg != `EDS_LOCK_ADDR || dir_write_reg) ##1 !ext_bus_active)
      else $error("blocked range reached external bus");

   lock_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_start && tgt == EDS_TGT_LOCK) |=> rdata_reg == {5'h00, $past(lock_reg)})
      else $error("lock status read wrong");

   ale_long_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(ale_out) && frame_reg.ale == 6'd6) |-> ale_out[*6] ##1 !ale_out)
      else $error("long address latch strobe width wrong");

   strobe_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(rd_strobe_n) || $rose(wr_strobe_n)) |-> str_cnt_reg == frame_reg.strobe)
      else $error("strobe width differs from stretch plan");

   wr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(wr_strobe_n) && frame_reg.hold == 6'd5) |-> low_addr_data_port_oe[*5])
      else $error("write data not held extra machine cycle");
endmodule // eds_top

// File: tb/eds_xmem_model.sv
// eds_xmem_model: external byte memory on the multiplexed address/data bus
// assumes: pins synchronous to hclk, address latched while the latch strobe is high
`timescale 1ns/1ps
module eds_xmem_model (
   input wire logic clk,
   input wire logic ale,
   input wire logic [7:0] ad_out,
   input wire logic [7:0] hi_addr,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] ad_in
);
   logic [7:0] mem [0:65535];
   logic [15:0] addr_reg = 16'h0000;
   logic rd_prev = 1'b0;
   logic [7:0] last = 8'h00;
   always @(posedge clk) begin
      if (ale) begin
         addr_reg <= {hi_addr, ad_out};
      end
      if (!wr_n) begin
         mem[addr_reg] <= ad_out;
      end
      rd_prev <= !rd_n;
      last <= ad_in;
   end
   // data stands during the strobe and one cycle after, else an ever-changing pattern
   assign ad_in = (!rd_n || rd_prev) ? mem[addr_reg] : ~last;
endmodule // eds_xmem_model

// File: tb/ext_data_memory_stretch_tb.sv
// ext_data_memory_stretch_tb: self-checking bench for the data-memory access unit
// assumes: eds_top as the one ahb-lite slave, external memory model on its pins
`timescale 1ns/1ps
`include "eds_defines.svh"
module ext_data_memory_stretch_tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ale_out, rd_strobe_n, wr_strobe_n;
   logic ext_bus_active, low_addr_data_port_oe;
   wire logic hready;
   logic [1:0] htrans;
   logic [2:0] hsize, security_lock_status;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] low_addr_data_port_in, low_addr_data_port_out, high_addr_port_out;
   int bad_count, samples_checked, cyc, t_done;
   int cnt [8];
   assign hready = hreadyout;
   eds_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .security_lock_status, .low_addr_data_port_in,
      .low_addr_data_port_out, .low_addr_data_port_oe, .high_addr_port_out, .ale_out,
      .rd_strobe_n, .wr_strobe_n, .ext_bus_active);
   eds_xmem_model u_mem (.clk(hclk), .ale(ale_out), .ad_out(low_addr_data_port_out),
      .hi_addr(high_addr_port_out), .rd_n(rd_strobe_n), .wr_n(wr_strobe_n),
      .ad_in(low_addr_data_port_in));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // pin activity counters, zeroed by the access task
   always @(posedge hclk) begin
      cyc++;
      cnt[0] += (ale_out === 1'b1);
      cnt[1] += (rd_strobe_n === 1'b0);
      cnt[2] += (wr_strobe_n === 1'b0);
      cnt[3] += (ext_bus_active === 1'b1);
      cnt[4] += (high_addr_port_out !== 8'h00);
      cnt[5]++;
      cnt[6] += (low_addr_data_port_oe === 1'b1);
      cnt[7] += (hresp !== 1'b0);
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   function automatic int e_tot(int s);
      return s < 4 ? 4 * (2 + s) : 4 * (5 + s);
   endfunction
   function automatic int e_str(int s);
      return s == 0 ? 2 : 4 * s;
   endfunction
   function automatic int e_ale(int s);
      return s < 4 ? 2 : 6;
   endfunction
   function automatic int e_hi(int s);
      return s == 0 ? 4 : (s < 4 ? 4 * s + 4 : 4 * s + 12);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      rd = hrdata;
   endtask
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
      input logic [31:0] mid, output logic [31:0] st, output logic [31:0] rv);
      int n;
      n = 0;
      ahb(1'b1, `EDS_OFS_ADDR, {16'h0, a}, rv);
      ahb(1'b1, `EDS_OFS_WDATA, {24'h0, d}, rv);
      cnt = '{default: 0};
      ahb(1'b1, `EDS_OFS_CMD, {30'h0, wr, 1'b1}, rv); // data moves only, no program map change
      if (mid !== 32'h0) ahb(1'b1, `EDS_OFS_CTRL, mid, rv);
      do begin
         ahb(1'b0, `EDS_OFS_STATUS, 32'h0, st);
         n++;
      end while (st[0] !== 1'b0 && n < 100);
      t_done = cnt[5];
      ahb(1'b0, `EDS_OFS_RDATA, 32'h0, rv);
   endtask
   task automatic one(input logic [31:0] c, input logic wr, input logic [15:0] a,
      input logic [7:0] d, input logic ext, input logic blk, input logic [7:0] er);
      logic [31:0] st, rv;
      ahb(1'b1, `EDS_OFS_CTRL, c, rv);
      acc(wr, a, d, 32'h0, st, rv);
      chk("bus used", {31'h0, ext}, {31'h0, cnt[3] != 0});
      chk("blocked", {31'h0, blk}, {31'h0, st[2]});
      chk("error response", 32'h0, 32'(cnt[7]));
      if (!wr) chk("read data", {24'h0, er}, rv);
   endtask
   task automatic t_reset();
      logic [31:0] st, rv;
      ahb(1'b0, `EDS_OFS_CTRL, 32'h0, rv);
      chk("ctrl reset", 32'h0000_0001, rv);
      acc(1'b1, 16'h2000, 8'h11, 32'h0, st, rv);
      chk("default frame", 32'h0000_000C, 32'(cnt[3]));
      $display("test reset done");
   endtask
   task automatic t_stretch();
      logic [31:0] st, rv;
      for (int s = 0; s < 8; s++) begin
         ahb(1'b1, `EDS_OFS_CTRL, 32'(16 + s), rv);
         acc(1'b1, 16'(16'h1200 + s), 8'(8'hA0 + s), 32'h0, st, rv);
         chk("frame", 32'(e_tot(s)), 32'(cnt[3]));
         chk("write strobe", 32'(e_str(s)), 32'(cnt[2]));
         chk("latch width", 32'(e_ale(s)), 32'(cnt[0]));
         chk("addr hold", 32'(e_hi(s)), 32'(cnt[4]));
         chk("data drive", 32'(e_hi(s)), 32'(cnt[6]));
         acc(1'b0, 16'(16'h1200 + s), 8'h00, 32'h0, st, rv);
         chk("read data", {24'h0, 8'(8'hA0 + s)}, rv);
         chk("read strobe", 32'(e_str(s)), 32'(cnt[1]));
         chk("addr drive", 32'(e_ale(s)), 32'(cnt[6]));
      end
      $display("test stretch done");
   endtask
   task automatic t_map();
      one(32'h01, 1'b1, 16'h0100, 8'h5A, 1'b1, 1'b0, 8'h00);
      one(32'h17, 1'b1, 16'h0100, 8'hC3, 1'b0, 1'b0, 8'h00);
      chk("internal time", 32'h1, {31'h0, t_done >= 11 && t_done <= 13});
      one(32'h11, 1'b0, 16'h0100, 8'h00, 1'b0, 1'b0, 8'hC3);
      one(32'h11, 1'b1, 16'h03FF, 8'h3C, 1'b0, 1'b0, 8'h00);
      one(32'h11, 1'b1, 16'h0400, 8'h77, 1'b1, 1'b0, 8'h00);
      one(32'h11, 1'b0, 16'h0400, 8'h00, 1'b1, 1'b0, 8'h77);
      one(32'h01, 1'b0, 16'h0100, 8'h00, 1'b1, 1'b0, 8'h5A);
      one(32'h21, 1'b0, 16'h0100, 8'h00, 1'b1, 1'b0, 8'h5A);
      one(32'h31, 1'b0, 16'h03FF, 8'h00, 1'b0, 1'b0, 8'h3C);
      one(32'h31, 1'b0, 16'h0400, 8'h00, 1'b0, 1'b1, 8'h00);
      one(32'h31, 1'b0, 16'hFFFB, 8'h00, 1'b0, 1'b1, 8'h00);
      one(32'h31, 1'b0, 16'hFFFD, 8'h00, 1'b0, 1'b1, 8'h00);
      one(32'h31, 1'b0, 16'hFFFC, 8'h00, 1'b0, 1'b0, 8'h05);
      one(32'h31, 1'b1, 16'hFFFC, 8'hFF, 1'b0, 1'b1, 8'h00);
      one(32'h31, 1'b0, 16'hFFFC, 8'h00, 1'b0, 1'b0, 8'h05);
      $display("test map done");
   endtask
   task automatic t_mid();
      logic [31:0] st, rv;
      ahb(1'b1, `EDS_OFS_CTRL, 32'h17, rv);
      acc(1'b0, 16'h1207, 8'h00, 32'h10, st, rv);
      chk("frame kept", 32'(e_tot(7)), 32'(cnt[3]));
      chk("read data", 32'hA7, rv);
      acc(1'b0, 16'h1207, 8'h00, 32'h0, st, rv);
      chk("frame new", 32'(e_tot(0)), 32'(cnt[3]));
      $display("test midchange done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      security_lock_status = 3'h5;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_stretch();
      t_map();
      t_mid();
      print_verdict();
   end
endmodule // ext_data_memory_stretch_tb
